// ---- abl_fifo.sv ----
// Pixel FIFO with registered read data
`include "abl_params.svh"
module abl_fifo #(
	parameter int W     = 17,
	parameter int DEPTH = `ABL_FIFO_DEPTH,
	parameter int SLACK = `ABL_FIFO_SLACK
) (
	input wire logic sys_clk,
	input wire logic rst,
	abl_stream_if.snk   wr,
	abl_stream_if.src   rd,
	output logic        overflow
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wptr_ff;
	logic [AW-1:0] rptr_ff;
	logic [AW:0]   cnt_ff;
	logic          out_valid_ff;
	logic [W-1:0]  out_data_ff;
	logic          push;
	logic          load;

	// Ready drops early: the input pins arrive through a two-stage sync
	assign wr.ready = (cnt_ff < (AW+1)'(DEPTH - SLACK));
	assign push     = wr.valid && (cnt_ff != (AW+1)'(DEPTH));
	assign load     = (cnt_ff != '0) && (!out_valid_ff || rd.ready);
	assign rd.valid = out_valid_ff;
	assign rd.data  = out_data_ff;
	assign overflow = wr.valid && !push;

	always_ff @(posedge sys_clk) begin
		if (push)
			mem[wptr_ff] <= wr.data;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wptr_ff <= '0;
			rptr_ff <= '0;
			cnt_ff  <= '0;
		end else begin
			if (push)
				wptr_ff <= (wptr_ff == AW'(DEPTH-1)) ? '0 : wptr_ff + 1'b1;
			if (load)
				rptr_ff <= (rptr_ff == AW'(DEPTH-1)) ? '0 : rptr_ff + 1'b1;
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(load);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			out_valid_ff <= 1'b0;
			out_data_ff  <= '0;
		end else if (load) begin
			out_valid_ff <= 1'b1;
			out_data_ff  <= mem[rptr_ff];
		end else if (rd.ready) begin
			out_valid_ff <= 1'b0;
		end
	end
endmodule // abl_fifo

// ---- abl_params.svh ----
// Constants for the background level tracker
`ifndef ABL_PARAMS_SVH
`define ABL_PARAMS_SVH
`define ABL_PIX_W          8
`define ABL_LINE_PIXELS    5000
`define ABL_DPI            400
`define ABL_STRIP_PIXELS   64
`define ABL_FIFO_DEPTH     16
`define ABL_FIFO_SLACK     2
`define ABL_REF_DEFAULT    8'hFF
`define ABL_DENSITY_STEP   4
`endif

// ---- abl_pkg.sv ----
// Types shared by the background level tracker
`include "abl_params.svh"
package abl_pkg;
	typedef logic [`ABL_PIX_W-1:0] pix_t;
	typedef logic [12:0]           pix_cnt_t;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_STRIP = 2'b01,
		ST_SEND  = 2'b11,
		ST_REST  = 2'b10
	} track_state_e;
endpackage

// ---- abl_sensor_model.sv ----
// Behavioural sensor board front end driving scan lines
module abl_sensor_model (
	input  wire logic    sys_clk,
	output logic          line_active,
	output logic          pix_valid,
	output abl_pkg::pix_t pix_odd,
	output abl_pkg::pix_t pix_even
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		line_active = 1'b0;
		pix_valid   = 1'b0;
		pix_odd     = 8'h00;
		pix_even    = 8'hFF;
	end
	// Pixels idle on inverse of last value, never stale
	task automatic send_line(input abl_pkg::pix_t fill,
			input abl_pkg::pix_t spike, input int at,
			input logic ramp, input logic dual, input int beats);
		int i;
		@(posedge sys_clk);
		line_active <= 1'b1;
		repeat (2) @(posedge sys_clk);
		for (i = 0; i < beats; i++) begin
			@(posedge sys_clk);
			pix_valid <= 1'b1;
			pix_odd   <= ramp ? 8'(i) : (i == at && !dual) ? spike : fill;
			pix_even  <= (i == at && dual) ? spike : fill;
			@(posedge sys_clk);
			pix_valid <= 1'b0;
			pix_odd   <= ~pix_odd;
			pix_even  <= ~pix_even;
		end
		repeat (6) @(posedge sys_clk);
		line_active <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask
endmodule // abl_sensor_model

// ---- abl_stream_if.sv ----
// Valid/ready stream carrier between tracker and its FIFO
interface abl_stream_if #(parameter int W = 17);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ---- auto_background_level_tracker.sv ----
// Per-line peak white tracking and A/D reference generation
`include "abl_params.svh"
module auto_background_level_tracker #(
	parameter int LINE_PIXELS  = `ABL_LINE_PIXELS,
	parameter int STRIP_PIXELS = `ABL_STRIP_PIXELS,
	parameter int FIFO_DEPTH   = `ABL_FIFO_DEPTH
) (
	input  wire logic          sys_clk,
	input  wire logic          rst,
	input  wire logic          line_active,
	input  wire logic          pix_valid,
	input  wire abl_pkg::pix_t pix_odd,
	input  wire abl_pkg::pix_t pix_even,
	input  wire logic          dual_channel,
	input  wire logic          auto_background_density,
	input  wire logic          manual_enable,
	input  wire logic [3:0]    manual_density,
	output logic               pix_ready,
	output abl_pkg::pix_t      ref_value,
	output logic               ref_strobe,
	output abl_pkg::pix_t      peak_level,
	output logic               pix_overflow,
	output logic               out_valid,
	input  wire logic          out_ready,
	output logic [15:0]        out_data,
	output logic               out_pair
);
	// Two-stage synchronisers for sensor board pins
	logic                 line_m_ff;
	logic                 line_s_ff;
	logic                 line_d_ff;
	logic                 valid_m_ff;
	logic                 valid_s_ff;
	abl_pkg::pix_t        odd_m_ff;
	abl_pkg::pix_t        odd_s_ff;
	abl_pkg::pix_t        even_m_ff;
	abl_pkg::pix_t        even_s_ff;

	abl_pkg::track_state_e state_ff;
	abl_pkg::track_state_e nxt_state;
	abl_pkg::pix_cnt_t    px_cnt_ff;
	abl_pkg::pix_cnt_t    nxt_px_cnt;
	abl_pkg::pix_t        peak_ff;
	abl_pkg::pix_t        ref_ff;
	logic                 strobe_ff;
	logic                 line_start;
	logic                 beat;
	logic                 in_line;
	abl_pkg::pix_t        beat_max;
	logic [1:0]           inc;

	abl_stream_if #(.W(17)) push_if ();
	abl_stream_if #(.W(17)) pop_if ();

	function automatic abl_pkg::pix_t whiter(input abl_pkg::pix_t a,
		input abl_pkg::pix_t b);
		// Larger code means whiter
		return (b > a) ? b : a;
	endfunction

	function automatic abl_pkg::pix_t ref_calc(input abl_pkg::pix_t base,
		input logic man_en, input logic [3:0] man);
		logic signed [10:0] sum;
		sum = $signed({3'b000, base});
		if (man_en)
			sum = sum + 11'($signed(man) * `ABL_DENSITY_STEP);
		if (sum < 0)
			return 8'h00;
		else if (sum > 11'sh0FF)
			return 8'hFF;
		return sum[7:0];
	endfunction

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			line_m_ff  <= 1'b0;
			line_s_ff  <= 1'b0;
			line_d_ff  <= 1'b0;
			valid_m_ff <= 1'b0;
			valid_s_ff <= 1'b0;
		end else begin
			line_m_ff  <= line_active;
			line_s_ff  <= line_m_ff;
			line_d_ff  <= line_s_ff;
			valid_m_ff <= pix_valid;
			valid_s_ff <= valid_m_ff;
		end
	end

	// Data needs no reset, it is only read with its valid
	always_ff @(posedge sys_clk) begin
		odd_m_ff  <= pix_odd;
		odd_s_ff  <= odd_m_ff;
		even_m_ff <= pix_even;
		even_s_ff <= even_m_ff;
	end

	assign line_start = line_s_ff && !line_d_ff;
	assign in_line    = (state_ff != abl_pkg::ST_IDLE);
	assign beat       = valid_s_ff && line_s_ff && in_line;
	assign inc        = dual_channel ? 2'd2 : 2'd1;
	assign beat_max   = dual_channel ? whiter(odd_s_ff, even_s_ff)
		: odd_s_ff;

	always_comb begin
		nxt_px_cnt = px_cnt_ff;
		if (line_start)
			nxt_px_cnt = '0;
		else if (beat && px_cnt_ff < 13'(LINE_PIXELS))
			nxt_px_cnt = px_cnt_ff + 13'(inc);
	end

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			abl_pkg::ST_IDLE:  nxt_state = abl_pkg::ST_IDLE;
			abl_pkg::ST_STRIP: begin
				if (nxt_px_cnt >= 13'(STRIP_PIXELS))
					nxt_state = abl_pkg::ST_SEND;
			end
			abl_pkg::ST_SEND:  nxt_state = abl_pkg::ST_REST;
			abl_pkg::ST_REST:  nxt_state = abl_pkg::ST_REST;
			default:           nxt_state = abl_pkg::ST_IDLE;
		endcase
		// A new line restarts tracking from any state
		if (line_start)
			nxt_state = abl_pkg::ST_STRIP;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_ff  <= abl_pkg::ST_IDLE;
			px_cnt_ff <= '0;
		end else begin
			state_ff  <= nxt_state;
			px_cnt_ff <= nxt_px_cnt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			peak_ff <= 8'h00;
		else if (line_start)
			peak_ff <= 8'h00;
		else if (beat && state_ff == abl_pkg::ST_STRIP)
			peak_ff <= whiter(peak_ff, beat_max);
	end

	// Reference is held between lines so the A/D controller sees a stable value
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ref_ff    <= `ABL_REF_DEFAULT;
			strobe_ff <= 1'b0;
		end else begin
			strobe_ff <= (state_ff == abl_pkg::ST_SEND);
			if (state_ff == abl_pkg::ST_SEND)
				ref_ff <= ref_calc(auto_background_density ? peak_ff
					: `ABL_REF_DEFAULT, manual_enable,
					manual_density);
		end
	end

	assign ref_value  = ref_ff;
	assign ref_strobe = strobe_ff;
	assign peak_level = peak_ff;

	assign push_if.valid = valid_s_ff && line_s_ff;
	assign push_if.data  = {dual_channel, even_s_ff, odd_s_ff};
	assign pix_ready     = push_if.ready;
	assign pop_if.ready  = out_ready;
	assign out_valid     = pop_if.valid;
	assign out_data      = pop_if.data[15:0];
	assign out_pair      = pop_if.data[16];

	abl_fifo #(
		.W     (17),
		.DEPTH (FIFO_DEPTH),
		.SLACK (`ABL_FIFO_SLACK)
	) u_fifo (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.wr       (push_if.snk),
		.rd       (pop_if.src),
		.overflow (pix_overflow)
	);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence strip_done_s;
		state_ff == abl_pkg::ST_STRIP && nxt_state == abl_pkg::ST_SEND
			&& !line_start;
	endsequence
	sequence ref_out_s;
		##1 state_ff == abl_pkg::ST_SEND ##1 ref_strobe;
	endsequence

	a_strobe_after_strip: assert property (strip_done_s |-> ref_out_s)
		else $error("reference not sent after strip");
	a_strobe_one_cycle: assert property (ref_strobe |=> !ref_strobe)
		else $error("reference strobe longer than one cycle");
	a_peak_clear_line: assert property (line_start |=> peak_ff == 8'h00)
		else $error("peak not cleared at line start");
	a_peak_never_drops: assert property (!line_start |=> peak_ff >= $past(peak_ff))
		else $error("peak decreased within a line");
	a_peak_outside_strip: assert property (state_ff != abl_pkg::ST_STRIP
		&& !line_start |=> $stable(peak_ff))
		else $error("peak changed outside strip");
	a_peak_tracks_beat: assert property (beat && state_ff == abl_pkg::ST_STRIP
		&& !line_start |=> peak_ff >= $past(beat_max))
		else $error("whiter strip sample missed");
	a_ref_from_peak: assert property (state_ff == abl_pkg::ST_SEND
		&& auto_background_density && !manual_enable
		|=> ref_value == $past(peak_ff))
		else $error("reference differs from peak");
	a_ref_manual_mix: assert property (state_ff == abl_pkg::ST_SEND
		&& auto_background_density && manual_enable
		|=> ref_value == ref_calc($past(peak_ff), 1'b1,
		$past(manual_density)))
		else $error("manual density not applied");
	a_line_restarts: assert property (line_start
		|=> state_ff == abl_pkg::ST_STRIP && px_cnt_ff == '0)
		else $error("line start did not restart tracking");
	a_count_bounded: assert property (px_cnt_ff <= 13'(LINE_PIXELS + 1))
		else $error("pixel count beyond line length");
	a_ref_stable_rest: assert property (state_ff == abl_pkg::ST_REST
		&& !line_start |=> $stable(ref_value))
		else $error("reference moved during conversion");
endmodule // auto_background_level_tracker

// ---- test_auto_background_level_tracker.sv ----
// Self-checking bench for the background level tracker
module test_auto_background_level_tracker;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LINE  = 32;
	localparam int STRIP = 8;
	logic sys_clk, rst, line_active, pix_valid, dual_channel;
	logic auto_background_density, manual_enable, out_ready;
	logic pix_ready, ref_strobe, pix_overflow, out_valid, out_pair;
	logic [3:0] manual_density;
	logic [15:0] out_data;
	abl_pkg::pix_t pix_odd, pix_even, ref_value, peak_level;
	int mismatches, checks, strobes, overflows, word_n;
	logic ready_low, ramp_chk;

	auto_background_level_tracker #(.LINE_PIXELS(LINE),
		.STRIP_PIXELS(STRIP), .FIFO_DEPTH(16)) dut (.sys_clk, .rst,
		.line_active, .pix_valid, .pix_odd, .pix_even, .dual_channel,
		.auto_background_density, .manual_enable, .manual_density,
		.pix_ready, .ref_value, .ref_strobe, .peak_level, .pix_overflow,
		.out_valid, .out_ready, .out_data, .out_pair);
	abl_sensor_model model (.sys_clk, .line_active, .pix_valid,
		.pix_odd, .pix_even);

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic chk(input string what, input logic [15:0] exp,
			input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	always @(posedge sys_clk) begin
		if (ref_strobe === 1'b1) strobes++;
		if (pix_overflow === 1'b1) overflows++;
		if (pix_ready === 1'b0) ready_low = 1'b1;
		if (ramp_chk && out_valid === 1'b1 && out_ready === 1'b1) begin
			chk("out_data", 16'(word_n), out_data);
			chk("out_pair", 16'h0000, {15'h0000, out_pair});
			word_n++;
		end
	end

	function automatic abl_pkg::pix_t exp_ref(input abl_pkg::pix_t pk);
		int v;
		v = auto_background_density ? int'(pk) : 255;
		if (manual_enable) v = v + 4 * $signed(manual_density);
		return v < 0 ? 8'h00 : v > 255 ? 8'hFF : 8'(v);
	endfunction

	// One line, then exactly one new reference must have gone out
	task automatic run(input abl_pkg::pix_t fill, input abl_pkg::pix_t spike,
			input int at, input logic dual, input abl_pkg::pix_t pk);
		strobes = 0;
		dual_channel <= dual;
		model.send_line(fill, spike, at, 1'b0, dual, dual ? LINE/2 : LINE);
		chk("strobes", 16'h0001, 16'(strobes));
		chk("peak_level", {8'h00, pk}, {8'h00, peak_level});
		chk("ref_value", {8'h00, exp_ref(pk)}, {8'h00, ref_value});
	endtask

	task automatic t_reset;
		chk("ref_reset", 16'h00FF, {8'h00, ref_value});
		chk("flags_reset", 16'h0001, {pix_overflow, ref_strobe, out_valid, pix_ready});
	endtask

	task automatic t_strip;
		run(8'h40, 8'hC0, 5, 1'b0, 8'hC0);
		run(8'h40, 8'hF0, 20, 1'b0, 8'h40);
		run(8'h30, 8'hE0, STRIP - 1, 1'b0, 8'hE0);
	endtask

	task automatic t_dual;
		run(8'h20, 8'hE0, 2, 1'b1, 8'hE0);
		run(8'h20, 8'hE0, 4, 1'b1, 8'h20);
	endtask

	task automatic t_manual;
		logic [6:0] tab [5] = '{7'h33, 7'h38, 7'h37, 7'h13, 7'h1F};
		int k;
		for (k = 0; k < 5; k++) begin
			auto_background_density <= tab[k][5];
			manual_enable <= tab[k][4];
			manual_density <= tab[k][3:0];
			run(k == 2 ? 8'hF0 : 8'h10, 8'h00, 0, 1'b0,
				k == 2 ? 8'hF0 : 8'h10);
		end
	endtask

	// Downstream stalls so the buffer fills and refuses, then drains
	task automatic t_fifo;
		out_ready <= 1'b0;
		ready_low = 1'b0;
		overflows = 0;
		word_n = 0;
		ramp_chk = 1'b1;
		model.send_line(8'h00, 8'h00, 0, 1'b1, 1'b0, LINE);
		chk("ready_low", 16'h0001, {15'h0000, ready_low});
		chk("overflow_seen", 16'h0001, 16'(overflows > 0));
		out_ready <= 1'b1;
		repeat (40) @(posedge sys_clk);
		ramp_chk = 1'b0;
		chk("drained", 16'h0001, 16'(word_n >= 16));
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		tally_and_finish;
	end

	initial begin
		mismatches = 0;
		checks = 0;
		ramp_chk = 1'b0;
		rst = 1'b1;
		dual_channel = 1'b0;
		auto_background_density = 1'b1;
		manual_enable = 1'b0;
		manual_density = 4'h0;
		out_ready = 1'b1;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		t_reset;
		t_strip;
		t_dual;
		t_manual;
		t_fifo;
		tally_and_finish;
	end
endmodule // test_auto_background_level_tracker
